// ===== shared/shift_swap_pkg.sv
// Constants, types and helper functions of the shift and swap unit
package shift_swap_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int DATA_W = 16;
	localparam int WAIT_W = 4;
	localparam int CNT_W = 6;
	localparam int BYTE_MSB = 7;
	localparam int WORD_MSB = 15;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {op_sll, op_sra, op_srl, op_swap} op_type;
	typedef enum logic [2:0] {cls_none, cls_first, cls_second, cls_single, cls_rmw} class_type;
	typedef enum logic [1:0] {tgt_reg, tgt_port, tgt_sfr, tgt_ext} target_type;

	// ----------------------------------------
	// Encoding lengths and state counts
	// ----------------------------------------
	localparam logic [1:0] SHIFT_BYTES_BIN = 2'h3;
	localparam logic [1:0] SHIFT_BYTES_SRC = 2'h2;
	localparam logic [1:0] SWAP_BYTES = 2'h1;
	localparam logic [5:0] SHIFT_STATES_BIN = 6'h02;
	localparam logic [5:0] SHIFT_STATES_SRC = 6'h01;
	localparam logic [5:0] SWAP_STATES = 6'h02;
	localparam logic [5:0] FIRST_PORT_ADD = 6'h01;
	localparam logic [5:0] FIRST_SFR_ADD = 6'h02;
	localparam logic [5:0] SECOND_PORT_ADD = 6'h02;
	localparam logic [5:0] SECOND_SFR_ADD = 6'h03;
	localparam logic [5:0] EXT_OFFSET = 6'h02;
	localparam logic [CNT_W-1:0] RESET_STATES = 6'h01;

	// Extra states for the operand location and timing class
	function automatic logic [5:0] extra_states(
		input class_type cls,
		input target_type tgt,
		input logic [WAIT_W-1:0] waits
	);
		logic [5:0] ext_once;
		ext_once = {2'h0, waits} + EXT_OFFSET;
		extra_states = 6'h00;
		if (cls == cls_first && tgt == tgt_port)
			extra_states = FIRST_PORT_ADD;
		else if (cls == cls_first && tgt == tgt_sfr)
			extra_states = FIRST_SFR_ADD;
		else if (cls == cls_second && tgt == tgt_port)
			extra_states = SECOND_PORT_ADD;
		else if (cls == cls_second && tgt == tgt_sfr)
			extra_states = SECOND_SFR_ADD;
		else if (cls == cls_single && tgt == tgt_ext)
			extra_states = ext_once;
		else if (cls == cls_rmw && tgt == tgt_ext)
			extra_states = {ext_once[4:0], 1'b0};
	endfunction : extra_states

	// Base states and bytes of an operation in the given encoding mode
	function automatic logic [5:0] base_states(input op_type op, input logic binary_mode);
		if (op == op_swap)
			base_states = SWAP_STATES;
		else
			base_states = binary_mode ? SHIFT_STATES_BIN : SHIFT_STATES_SRC;
	endfunction : base_states

	function automatic logic [1:0] op_bytes(input op_type op, input logic binary_mode);
		if (op == op_swap)
			op_bytes = SWAP_BYTES;
		else
			op_bytes = binary_mode ? SHIFT_BYTES_BIN : SHIFT_BYTES_SRC;
	endfunction : op_bytes

endpackage : shift_swap_pkg

// ===== verilog/state_timing.sv
// State count calculator for one accepted operation
`timescale 1ns/1ps
module state_timing
	import shift_swap_pkg::*;
(
	input logic clk_sys,
	input logic reset,
	input logic load,
	input op_type op,
	input logic binary_mode,
	input class_type acc_class,
	input target_type target,
	input logic [WAIT_W-1:0] wait_states,
	output logic [CNT_W-1:0] base_states_ff,
	output logic [CNT_W-1:0] total_states_ff
);

	// ----------------------------------------
	// Registered counts, held until the next load
	// ----------------------------------------
	// Registered so the long add chain stays off the control path
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			base_states_ff <= RESET_STATES;
			total_states_ff <= RESET_STATES;
		end
		else if (load)
		begin
			base_states_ff <= base_states(op, binary_mode);
			total_states_ff <= base_states(op, binary_mode)
				+ extra_states(acc_class, target, wait_states);
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_shift_base_states: assert property (@(posedge clk_sys) disable iff (reset)
		load && op != op_swap |=> base_states_ff == ($past(binary_mode) ? 6'h02 : 6'h01))
		else $error("shift base state count wrong");
	chk_first_class_add: assert property (@(posedge clk_sys) disable iff (reset)
		load && acc_class == cls_first && target != tgt_reg && target != tgt_ext
		|=> total_states_ff - base_states_ff == ($past(target) == tgt_port ? 6'h01 : 6'h02))
		else $error("first class extra states wrong");
	chk_second_class_add: assert property (@(posedge clk_sys) disable iff (reset)
		load && acc_class == cls_second && target != tgt_reg && target != tgt_ext
		|=> total_states_ff - base_states_ff == ($past(target) == tgt_port ? 6'h02 : 6'h03))
		else $error("second class extra states wrong");
	chk_single_ext_add: assert property (@(posedge clk_sys) disable iff (reset)
		load && acc_class == cls_single && target == tgt_ext
		|=> total_states_ff == base_states_ff + {2'h0, $past(wait_states)} + 6'h02)
		else $error("single access external extension wrong");
	chk_rmw_ext_add: assert property (@(posedge clk_sys) disable iff (reset)
		load && acc_class == cls_rmw && target == tgt_ext
		|=> total_states_ff == base_states_ff + 6'h04 + {1'b0, $past(wait_states), 1'b0})
		else $error("read modify write external extension wrong");

endmodule : state_timing

// ===== verilog/shift_swap_logic_unit.sv
// Shift and nibble swap execution unit with state timing
// Behaviour
// - Left shift: zero in, msb to carry
// - Arithmetic right: msb kept, bit0 to carry
// - Logical right: msb cleared, bit0 to carry
// - Swap accumulator nibbles; one byte, two states
// - Shifts: binary 3 bytes/2, source 2/1
// - First class: port +1, peripheral +2
// - Second class: port +2, peripheral +3
// - Single access external: add wait plus two
// - Read-modify-write external: twice wait plus four
`timescale 1ns/1ps
module shift_swap_logic_unit
	import shift_swap_pkg::*;
(
	input logic clk_sys,
	input logic reset,
	input logic start,
	input op_type op,
	input logic word_op,
	input logic binary_mode,
	input class_type acc_class,
	input target_type target,
	input logic [WAIT_W-1:0] wait_states,
	input logic [DATA_W-1:0] operand_in,
	input logic [7:0] accumulator,
	input logic carry_in,
	output logic [DATA_W-1:0] result_ff,
	output logic carry_flag_ff,
	output logic [1:0] byte_count_ff,
	output logic busy_ff,
	output logic done_ff
);

	typedef enum logic {st_idle, st_exec} fsm_type;

	fsm_type state_ff;
	fsm_type nxt_state;
	logic [CNT_W-1:0] elapsed_ff;
	logic [CNT_W-1:0] base_states_ff;
	logic [CNT_W-1:0] total_states_ff;
	logic accept;
	logic last_state;
	logic [DATA_W-1:0] nxt_result;
	logic nxt_carry;
	logic [DATA_W-1:0] prev_operand_ff;
	logic [7:0] prev_accumulator_ff;
	logic [CNT_W-1:0] busy_run_ff;

	// Requests while busy are ignored; the core control never overlaps them
	assign accept = start && state_ff == st_idle;
	assign last_state = state_ff == st_exec && elapsed_ff == total_states_ff;

	// ----------------------------------------
	// Timing calculator
	// ----------------------------------------
	state_timing i_state_timing (
		.clk_sys(clk_sys),
		.reset(reset),
		.load(accept),
		.op(op),
		.binary_mode(binary_mode),
		.acc_class(acc_class),
		.target(target),
		.wait_states(wait_states),
		.base_states_ff(base_states_ff),
		.total_states_ff(total_states_ff)
	);

	// ----------------------------------------
	// Datapath
	// ----------------------------------------
	// Byte operands keep the upper byte zero so the output is defined
	always_comb
	begin
		nxt_result = result_ff;
		nxt_carry = carry_flag_ff;
		unique case (op)
			op_sll:
			begin
				if (word_op)
				begin
					nxt_result = {operand_in[WORD_MSB-1:0], 1'b0};
					nxt_carry = operand_in[WORD_MSB];
				end
				else
				begin
					nxt_result = {8'h00, operand_in[BYTE_MSB-1:0], 1'b0};
					nxt_carry = operand_in[BYTE_MSB];
				end
			end
			op_sra:
			begin
				if (word_op)
					nxt_result = {operand_in[WORD_MSB], operand_in[WORD_MSB:1]};
				else
					nxt_result = {8'h00, operand_in[BYTE_MSB], operand_in[BYTE_MSB:1]};
				nxt_carry = operand_in[0];
			end
			op_srl:
			begin
				if (word_op)
					nxt_result = {1'b0, operand_in[WORD_MSB:1]};
				else
					nxt_result = {8'h00, 1'b0, operand_in[BYTE_MSB:1]};
				nxt_carry = operand_in[0];
			end
			op_swap:
			begin
				nxt_result = {8'h00, accumulator[3:0], accumulator[7:4]};
				nxt_carry = carry_in; // Swap leaves carry alone
			end
		endcase
	end

	// Result and carry latch at acceptance and stand until the next one
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			result_ff <= 16'h0000;
			carry_flag_ff <= 1'b0;
			byte_count_ff <= 2'h0;
		end
		else if (accept)
		begin
			result_ff <= nxt_result;
			carry_flag_ff <= nxt_carry;
			byte_count_ff <= op_bytes(op, binary_mode);
		end
	end

	// ----------------------------------------
	// State sequencer
	// ----------------------------------------
	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			st_idle:
				if (start)
					nxt_state = st_exec;
			st_exec:
				if (last_state)
					nxt_state = st_idle;
		endcase
	end

	// One clock per state; done rises in the clock after the last state
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			state_ff <= st_idle;
			elapsed_ff <= RESET_STATES;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			busy_ff <= nxt_state == st_exec;
			done_ff <= last_state;
			if (accept)
				elapsed_ff <= RESET_STATES;
			else if (state_ff == st_exec)
				elapsed_ff <= elapsed_ff + 6'h01;
		end
	end

	// ----------------------------------------
	// Check helpers
	// ----------------------------------------
	// One-cycle-old copies of the inputs, so checks can slice them after the accept edge
	always_ff @(posedge clk_sys)
	begin
		prev_operand_ff <= operand_in;
		prev_accumulator_ff <= accumulator;
	end

	// Busy cycles counted apart from the sequencer, so a wrong stop point shows up
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			busy_run_ff <= 6'h00;
		else if (busy_ff)
			busy_run_ff <= busy_run_ff + 6'h01;
		else
			busy_run_ff <= 6'h00;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_sll_byte_result: assert property (@(posedge clk_sys) disable iff (reset)
		accept && op == op_sll && !word_op
		|=> result_ff[7:0] == {prev_operand_ff[6:0], 1'b0}
			&& carry_flag_ff == prev_operand_ff[7])
		else $error("byte left shift wrong");
	chk_sra_word_result: assert property (@(posedge clk_sys) disable iff (reset)
		accept && op == op_sra && word_op
		|=> result_ff == {prev_operand_ff[15], prev_operand_ff[15:1]}
			&& carry_flag_ff == prev_operand_ff[0])
		else $error("word arithmetic right shift wrong");
	chk_srl_result: assert property (@(posedge clk_sys) disable iff (reset)
		accept && op == op_srl && !word_op
		|=> result_ff[7] == 1'b0 && result_ff[6:0] == prev_operand_ff[7:1]
			&& carry_flag_ff == prev_operand_ff[0])
		else $error("byte logical right shift wrong");
	chk_sll_word_msb: assert property (@(posedge clk_sys) disable iff (reset)
		accept && op == op_sll && word_op |=> carry_flag_ff == prev_operand_ff[15])
		else $error("word shift carry not from bit 15");
	chk_byte_upper_zero: assert property (@(posedge clk_sys) disable iff (reset)
		accept && !word_op && op != op_swap |=> result_ff[15:8] == 8'h00)
		else $error("byte result upper byte not zero");
	chk_swap_timing: assert property (@(posedge clk_sys) disable iff (reset)
		accept && op == op_swap && acc_class == cls_none
		|=> result_ff[7:0] == {prev_accumulator_ff[3:0], prev_accumulator_ff[7:4]}
			&& byte_count_ff == 2'h1 && busy_ff
			##1 busy_ff && !done_ff ##1 done_ff && !busy_ff)
		else $error("swap result or timing wrong");
	chk_shift_src_timing: assert property (@(posedge clk_sys) disable iff (reset)
		accept && op != op_swap && !binary_mode && acc_class == cls_none
		|=> byte_count_ff == 2'h2 && done_ff == 1'b0 ##0 busy_ff ##1 done_ff && !busy_ff)
		else $error("source mode shift timing wrong");
	chk_done_after_total: assert property (@(posedge clk_sys) disable iff (reset)
		done_ff |-> busy_run_ff == total_states_ff)
		else $error("done not at counted state total");

endmodule : shift_swap_logic_unit

// ===== verification/test_shift_swap_logic_unit.sv
// Self-checking testbench of the shift and swap unit
`timescale 1ns/1ps
module test_shift_swap_logic_unit import shift_swap_pkg::*;;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic start = 1'b0;
	op_type op = op_sll;
	logic word_op = 1'b0;
	logic binary_mode = 1'b0;
	class_type acc_class = cls_none;
	target_type target = tgt_reg;
	logic [WAIT_W-1:0] wait_states = 4'h0;
	logic [DATA_W-1:0] operand_in = 16'h0000;
	logic [7:0] accumulator = 8'h00;
	logic carry_in = 1'b0;
	logic [DATA_W-1:0] result_ff;
	logic carry_flag_ff;
	logic [1:0] byte_count_ff;
	logic busy_ff;
	logic done_ff;
	int errors = 0;
	int cmp_count = 0;

	// 100 ns period core clock
	always #50 clk_sys = ~clk_sys;

	shift_swap_logic_unit i_shift_swap_logic_unit (
		.clk_sys(clk_sys), .reset(reset), .start(start), .op(op), .word_op(word_op),
		.binary_mode(binary_mode), .acc_class(acc_class), .target(target),
		.wait_states(wait_states), .operand_in(operand_in), .accumulator(accumulator),
		.carry_in(carry_in), .result_ff(result_ff), .carry_flag_ff(carry_flag_ff),
		.byte_count_ff(byte_count_ff), .busy_ff(busy_ff), .done_ff(done_ff)
	);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	// One operation: inputs at the falling edge, results checked one cycle after accept,
	// then busy cycles counted; the bound keeps a stuck busy from hanging the run
	task automatic run(input op_type o, input logic w, input logic b, input class_type c,
		input target_type t, input logic [3:0] n, input logic [15:0] d, input logic [7:0] a,
		input logic ci, input logic [15:0] er, input logic ecy, input logic [1:0] eb,
		input int et);
		int cycles;
		@(negedge clk_sys);
		op = o;
		word_op = w;
		binary_mode = b;
		acc_class = c;
		target = t;
		wait_states = n;
		operand_in = d;
		accumulator = a;
		carry_in = ci;
		start = 1'b1;
		@(negedge clk_sys);
		start = 1'b0;
		check("result", er, result_ff);
		check("carry", {15'h0000, ecy}, {15'h0000, carry_flag_ff});
		check("bytes", {14'h0000, eb}, {14'h0000, byte_count_ff});
		cycles = 0;
		while (busy_ff === 1'b1 && cycles < 80)
		begin
			cycles++;
			@(negedge clk_sys);
		end
		if (cycles >= 80)
		begin
			errors++;
			$display("MISMATCH busy expected 0 seen 1");
			test_done();
		end
		check("states", et[15:0], cycles[15:0]);
		check("done", 16'h0001, {15'h0000, done_ff});
	endtask : run

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_sll;
		run(op_sll, 0, 1, cls_none, tgt_reg, 0, 16'hab81, 0, 0, 16'h0002, 1, 2'h3, 2);
		run(op_sll, 1, 0, cls_none, tgt_reg, 0, 16'h4001, 0, 1, 16'h8002, 0, 2'h2, 1);
		$display("test_sll done");
	endtask : test_sll

	// Carry in set so a carry that is merely held shows up
	task automatic test_sra;
		run(op_sra, 0, 1, cls_none, tgt_reg, 0, 16'h1281, 0, 0, 16'h00c0, 1, 2'h3, 2);
		run(op_sra, 1, 0, cls_none, tgt_reg, 0, 16'h8002, 0, 1, 16'hc001, 0, 2'h2, 1);
		$display("test_sra done");
	endtask : test_sra

	task automatic test_srl;
		run(op_srl, 0, 0, cls_none, tgt_reg, 0, 16'hff81, 0, 0, 16'h0040, 1, 2'h2, 1);
		run(op_srl, 1, 1, cls_none, tgt_reg, 0, 16'h8001, 0, 0, 16'h4000, 1, 2'h3, 2);
		$display("test_srl done");
	endtask : test_srl

	// Swap costs the same in both modes and leaves carry alone
	task automatic test_swap;
		run(op_swap, 0, 1, cls_none, tgt_reg, 0, 16'hffff, 8'h3c, 1, 16'h00c3, 1, 2'h1, 2);
		run(op_swap, 1, 0, cls_none, tgt_reg, 0, 16'hffff, 8'ha5, 0, 16'h005a, 0, 2'h1, 2);
		$display("test_swap done");
	endtask : test_swap

	task automatic test_classes;
		run(op_sll, 0, 0, cls_first, tgt_port, 0, 0, 0, 0, 0, 0, 2'h2, 2);
		run(op_sll, 0, 0, cls_first, tgt_sfr, 0, 0, 0, 0, 0, 0, 2'h2, 3);
		run(op_sll, 0, 0, cls_second, tgt_port, 0, 0, 0, 0, 0, 0, 2'h2, 3);
		run(op_sll, 0, 0, cls_second, tgt_sfr, 0, 0, 0, 0, 0, 0, 2'h2, 4);
		run(op_sll, 0, 0, cls_first, tgt_ext, 5, 0, 0, 0, 0, 0, 2'h2, 1);
		$display("test_classes done");
	endtask : test_classes

	// Wait counts at both ends of the field
	task automatic test_ext;
		run(op_srl, 0, 1, cls_single, tgt_ext, 0, 0, 0, 0, 0, 0, 2'h3, 4);
		run(op_srl, 0, 1, cls_single, tgt_ext, 15, 0, 0, 0, 0, 0, 2'h3, 19);
		run(op_srl, 0, 0, cls_rmw, tgt_ext, 0, 0, 0, 0, 0, 0, 2'h2, 5);
		run(op_srl, 0, 0, cls_rmw, tgt_ext, 15, 0, 0, 0, 0, 0, 2'h2, 35);
		run(op_srl, 0, 0, cls_single, tgt_port, 7, 0, 0, 0, 0, 0, 2'h2, 1);
		$display("test_ext done");
	endtask : test_ext

	// A start held through busy is ignored; only the first request lands
	task automatic test_refused;
		@(negedge clk_sys);
		op = op_sll;
		word_op = 1'b1;
		binary_mode = 1'b1;
		acc_class = cls_none;
		target = tgt_reg;
		operand_in = 16'h0001;
		start = 1'b1;
		@(negedge clk_sys);
		op = op_srl;
		operand_in = 16'h8000;
		@(negedge clk_sys);
		start = 1'b0;
		check("held result", 16'h0002, result_ff);
		check("held busy", 16'h0001, {15'h0000, busy_ff});
		@(negedge clk_sys);
		check("held done", 16'h0001, {15'h0000, done_ff});
		check("held carry", 16'h0000, {15'h0000, carry_flag_ff});
		$display("test_refused done");
	endtask : test_refused

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (4) @(negedge clk_sys);
		reset = 1'b0;
		check("reset busy", 16'h0000, {15'h0000, busy_ff});
		check("reset result", 16'h0000, result_ff);
		test_sll();
		test_sra();
		test_srl();
		test_swap();
		test_classes();
		test_ext();
		test_refused();
		test_done();
	end

endmodule : test_shift_swap_logic_unit
